// *** pef_pkg.sv ***
// Purpose: Shared constants and types for the port E/F pin multiplexer.
// Assumes: APB word offsets; bit positions are within 8-bit registers.
// Notes: Port F pins are held at register bits 7:2.
package pef_pkg;
    localparam logic [7:0] PEF_OFF_PE_PIN = 8'h00;
    localparam logic [7:0] PEF_OFF_PE_LAT = 8'h04;
    localparam logic [7:0] PEF_OFF_PE_DIR = 8'h08;
    localparam logic [7:0] PEF_OFF_PG = 8'h0C;
    localparam logic [7:0] PEF_OFF_PF_PIN = 8'h10;
    localparam logic [7:0] PEF_OFF_PF_LAT = 8'h14;
    localparam logic [7:0] PEF_OFF_PF_DIR = 8'h18;
    localparam logic [7:0] PEF_OFF_ANA_LO = 8'h1C;
    localparam logic [7:0] PEF_OFF_ANA_HI = 8'h20;
    localparam logic [7:0] PEF_OFF_USB_CFG = 8'h24;
    localparam logic [7:0] PEF_OFF_CFG = 8'h28;
    localparam int PEF_PG_DPU_BIT = 7;
    localparam int PEF_PG_EPU_BIT = 6;
    localparam int PEF_PG_JPU_BIT = 5;
    localparam int PEF_USB_OFF_BIT = 3;
    localparam int PEF_ANA_RF2_BIT = 7;
    localparam int PEF_ANA_RF5_BIT = 2;
    localparam int PEF_ANA_RF6_BIT = 3;
    localparam int PEF_CFG_PWMMX_BIT = 0;
    localparam int PEF_CFG_CCP2MX_BIT = 1;
    localparam int PEF_CFG_PPMX_BIT = 2;
    localparam int PEF_CFG_HIZ_BIT = 3;
    localparam logic [7:0] PEF_PF_MASK = 8'hFC;
    localparam logic [7:0] PEF_PG_MASK = 8'hE0;
    localparam logic [7:0] PEF_CFG_MASK = 8'h0F;
    localparam logic [7:0] PEF_DIR_RST = 8'hFF;
    localparam logic [7:0] PEF_LAT_RST = 8'h00;
    localparam logic [7:0] PEF_PG_RST = 8'h00;
    localparam logic [7:0] PEF_ANA_RST = 8'h00;
    localparam logic [7:0] PEF_USB_RST = 8'h00;
    localparam logic [7:0] PEF_CFG_RST = 8'h07;
    localparam int PEF_NPIN = 7;

    typedef struct packed {
        logic ext_en;
        logic ext_oe;
        logic ext_d;
        logic pwm_en;
        logic pwm_d;
        logic pwm_hiz;
        logic ccp_en;
        logic ccp_d;
        logic pp_en;
        logic pp_oe;
        logic pp_d;
        logic lat;
        logic dir;
    } pef_pin_req_t;
endpackage

// *** pef_pin_mux.sv ***
// Purpose: Priority multiplexer for one shared pin.
// Assumes: Request fields already gated by variant and remap settings.
// Notes: Purely combinational; the top module registers the result.
module pef_pin_mux (
    input wire pef_pkg::pef_pin_req_t req,
    output logic pin_out,
    output logic pin_oe
);
    always_comb begin
        pin_out = req.lat;
        pin_oe = 1'b0;
        if (req.ext_en) begin
            pin_oe = req.ext_oe;
            pin_out = req.ext_d;
        // PWM beats latch and parallel port
        end else if (req.pwm_en && !req.dir) begin
            pin_oe = !req.pwm_hiz;
            pin_out = req.pwm_d;
        end else if (req.ccp_en && !req.dir) begin
            pin_oe = 1'b1;
            pin_out = req.ccp_d;
        end else if (req.pp_en) begin
            pin_oe = req.pp_oe;
            pin_out = req.pp_d;
        end else begin
            pin_oe = !req.dir;
            pin_out = req.lat;
        end
    end
endmodule

// *** pef_port_ef.sv ***
// Purpose: Port E bits 7:5 and port F pin logic with APB register access.
// Assumes: Pin inputs synchronous to core_clk; peripherals supply own data.
// Notes: Pin outputs lag the muxed request by one clock.
module pef_port_ef #(
    parameter bit PIN80 = 1'b1
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] east_pin_in,
    output logic [2:0] east_pin_out,
    output logic [2:0] east_pin_oe,
    input wire logic [5:0] f_pin_in,
    output logic [5:0] f_pin_out,
    output logic [5:0] f_pin_oe,
    input wire logic extmem_en,
    input wire logic extmem_oe,
    input wire logic [2:0] extmem_ad_out,
    output logic [2:0] extmem_ad_in,
    input wire logic parport_en,
    input wire logic parport_address_9,
    input wire logic parport_address_10,
    input wire logic parport_address_11,
    input wire logic parport_data_en,
    input wire logic parport_data_oe,
    input wire logic [2:0] parport_data_out,
    output logic [2:0] parport_data_in,
    input wire logic pwm1_active,
    input wire logic pwm2_active,
    input wire logic pwm1_channel_b,
    input wire logic pwm1_channel_c,
    input wire logic pwm2_channel_a,
    input wire logic pwm_shutdown,
    input wire logic capcomp2_en,
    input wire logic capcomp2_out,
    output logic capcomp2_capture,
    input wire logic usb_oe,
    input wire logic usb_dm_out,
    input wire logic usb_dp_out,
    output logic usb_dm_in,
    output logic usb_dp_in,
    output logic port_d_pullup_en,
    output logic port_e_pullup_en,
    output logic port_j_pullup_en
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] e_lat_ff;
    logic [7:0] e_dir_ff;
    logic [7:0] pg_ff;
    logic [7:0] f_lat_ff;
    logic [7:0] f_dir_ff;
    logic [7:0] ana_lo_ff;
    logic [7:0] ana_hi_ff;
    logic [7:0] usb_cfg_ff;
    logic [7:0] cfg_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] nxt_prdata;
    logic nxt_slverr;
    logic wr_en;
    logic [7:0] wdat;
    logic [2:0] east_out_ff;
    logic [2:0] east_oe_ff;
    logic [5:0] f_out_ff;
    logic [5:0] f_oe_ff;
    logic [2:0] ext_in_ff;
    logic [2:0] pp_in_ff;
    logic ccp_cap_ff;
    logic usb_dm_ff;
    logic usb_dp_ff;
    logic ext_active;
    logic usb_off;
    logic [7:0] pf_read;
    pef_pkg::pef_pin_req_t req [pef_pkg::PEF_NPIN];
    logic [pef_pkg::PEF_NPIN-1:0] mux_out;
    logic [pef_pkg::PEF_NPIN-1:0] mux_oe;

    generate
        if (PIN80 !== 1'b0 && PIN80 !== 1'b1) begin : g_bad_variant
            $error("PIN80 must be 0 or 1");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state so read data comes from a flop
    assign wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;
    assign wdat = pwdata[7:0];
    assign usb_off = usb_cfg_ff[pef_pkg::PEF_USB_OFF_BIT];
    // memory bus only in the large package
    assign ext_active = PIN80 && extmem_en;

    always_comb begin
        pf_read = 8'h00;
        pf_read[7:2] = f_pin_in;
        if (!ana_lo_ff[pef_pkg::PEF_ANA_RF2_BIT]) begin
            pf_read[2] = 1'b0;
        end
        if (!ana_hi_ff[pef_pkg::PEF_ANA_RF5_BIT]) begin
            pf_read[5] = 1'b0;
        end
        if (!ana_hi_ff[pef_pkg::PEF_ANA_RF6_BIT]) begin
            pf_read[6] = 1'b0;
        end
        // digital read only with transceiver off
        if (!usb_off) begin
            pf_read[4:3] = 2'h0;
        end
    end

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_slverr = 1'b0;
        case (paddr)
            // port reads pins, latch reads latch
            pef_pkg::PEF_OFF_PE_PIN: nxt_prdata[7:5] = east_pin_in;
            pef_pkg::PEF_OFF_PE_LAT: nxt_prdata[7:0] = e_lat_ff;
            pef_pkg::PEF_OFF_PE_DIR: nxt_prdata[7:0] = e_dir_ff;
            pef_pkg::PEF_OFF_PG: nxt_prdata[7:0] = pg_ff;
            pef_pkg::PEF_OFF_PF_PIN: nxt_prdata[7:0] = pf_read;
            pef_pkg::PEF_OFF_PF_LAT: nxt_prdata[7:0] = f_lat_ff;
            pef_pkg::PEF_OFF_PF_DIR: nxt_prdata[7:0] = f_dir_ff;
            pef_pkg::PEF_OFF_ANA_LO: nxt_prdata[7:0] = ana_lo_ff;
            pef_pkg::PEF_OFF_ANA_HI: nxt_prdata[7:0] = ana_hi_ff;
            pef_pkg::PEF_OFF_USB_CFG: nxt_prdata[7:0] = usb_cfg_ff;
            pef_pkg::PEF_OFF_CFG: nxt_prdata[7:0] = cfg_ff;
            default: nxt_slverr = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            if (psel && !penable) begin
                prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
                pslverr_ff <= nxt_slverr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port E registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            e_lat_ff <= pef_pkg::PEF_LAT_RST;
            e_dir_ff <= pef_pkg::PEF_DIR_RST;
            pg_ff <= pef_pkg::PEF_PG_RST;
        end else if (wr_en) begin
            if (paddr == pef_pkg::PEF_OFF_PE_PIN || paddr == pef_pkg::PEF_OFF_PE_LAT) begin
                e_lat_ff <= wdat;
            end
            if (paddr == pef_pkg::PEF_OFF_PE_DIR) begin
                e_dir_ff <= wdat;
            end
            // pull-up bits, J absent on small package
            if (paddr == pef_pkg::PEF_OFF_PG) begin
                pg_ff <= wdat & pef_pkg::PEF_PG_MASK;
                pg_ff[pef_pkg::PEF_PG_JPU_BIT] <= PIN80 && wdat[pef_pkg::PEF_PG_JPU_BIT];
            end
        end
    end

    // Port F and configuration registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            f_lat_ff <= pef_pkg::PEF_LAT_RST;
            f_dir_ff <= pef_pkg::PEF_DIR_RST & pef_pkg::PEF_PF_MASK;
            ana_lo_ff <= pef_pkg::PEF_ANA_RST;
            ana_hi_ff <= pef_pkg::PEF_ANA_RST;
            usb_cfg_ff <= pef_pkg::PEF_USB_RST;
            cfg_ff <= pef_pkg::PEF_CFG_RST;
        end else if (wr_en) begin
            // six pins, each with own direction bit; RF3 and RF4 pins take their direction from USB
            if (paddr == pef_pkg::PEF_OFF_PF_PIN || paddr == pef_pkg::PEF_OFF_PF_LAT) begin
                f_lat_ff <= wdat & pef_pkg::PEF_PF_MASK;
            end
            if (paddr == pef_pkg::PEF_OFF_PF_DIR) begin
                f_dir_ff <= wdat & pef_pkg::PEF_PF_MASK;
            end
            if (paddr == pef_pkg::PEF_OFF_ANA_LO) begin
                ana_lo_ff <= wdat;
            end
            if (paddr == pef_pkg::PEF_OFF_ANA_HI) begin
                ana_hi_ff <= wdat;
            end
            if (paddr == pef_pkg::PEF_OFF_USB_CFG) begin
                usb_cfg_ff <= wdat;
            end
            if (paddr == pef_pkg::PEF_OFF_CFG) begin
                cfg_ff <= wdat & pef_pkg::PEF_CFG_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Request assembly: index 0..2 east bits 5..7, 3..6 port F bits 2,5,6,7
    always_comb begin
        for (int i = 0; i < pef_pkg::PEF_NPIN; i++) begin
            req[i] = '0;
            req[i].pwm_hiz = pwm_shutdown && cfg_ff[pef_pkg::PEF_CFG_HIZ_BIT];
        end
        for (int k = 0; k < 3; k++) begin
            req[k].ext_en = ext_active;
            req[k].ext_oe = extmem_oe;
            req[k].ext_d = extmem_ad_out[k];
            req[k].pp_en = parport_en && cfg_ff[pef_pkg::PEF_CFG_PPMX_BIT];
            req[k].pp_oe = 1'b1;
            req[k].lat = e_lat_ff[5+k];
            req[k].dir = e_dir_ff[5+k];
        end
        req[0].pp_d = parport_address_11;
        req[1].pp_d = parport_address_10;
        req[2].pp_d = parport_address_9;
        // unit 1 channels need remap and large package
        req[0].pwm_en = pwm1_active && PIN80 && cfg_ff[pef_pkg::PEF_CFG_PWMMX_BIT];
        req[0].pwm_d = pwm1_channel_c;
        req[1].pwm_en = pwm1_active && PIN80 && cfg_ff[pef_pkg::PEF_CFG_PWMMX_BIT];
        req[1].pwm_d = pwm1_channel_b;
        // unit 2 here only with its remap cleared
        req[2].pwm_en = pwm2_active && !cfg_ff[pef_pkg::PEF_CFG_CCP2MX_BIT];
        req[2].pwm_d = pwm2_channel_a;
        req[2].ccp_en = capcomp2_en && !cfg_ff[pef_pkg::PEF_CFG_CCP2MX_BIT];
        req[2].ccp_d = capcomp2_out;
        req[3].lat = f_lat_ff[2];
        req[3].dir = f_dir_ff[2];
        for (int k = 0; k < 3; k++) begin
            // parallel data on port F when remap is 0, large package only
            req[4+k].pp_en = PIN80 && parport_data_en && !cfg_ff[pef_pkg::PEF_CFG_PPMX_BIT];
            req[4+k].pp_oe = parport_data_oe;
            req[4+k].pp_d = parport_data_out[2-k];
            req[4+k].lat = f_lat_ff[5+k];
            req[4+k].dir = f_dir_ff[5+k];
        end
    end

    generate
        for (genvar g = 0; g < pef_pkg::PEF_NPIN; g++) begin : g_mux
            pef_pin_mux u_mux (
                .req(req[g]),
                .pin_out(mux_out[g]),
                .pin_oe(mux_oe[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Registered pin drive; one flop keeps the pads glitch free
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            east_out_ff <= 3'h0;
            east_oe_ff <= 3'h0;
            f_out_ff <= 6'h00;
            f_oe_ff <= 6'h00;
        end else begin
            east_out_ff <= mux_out[2:0];
            east_oe_ff <= mux_oe[2:0];
            f_out_ff[0] <= mux_out[3];
            f_oe_ff[0] <= mux_oe[3];
            f_out_ff[5:3] <= mux_out[6:4];
            f_oe_ff[5:3] <= mux_oe[6:4];
            // USB owns direction of bits 3,4
            f_oe_ff[2:1] <= usb_off ? 2'h0 : {2{usb_oe}};
            f_out_ff[2:1] <= usb_off ? 2'h0 : {usb_dp_out, usb_dm_out};
        end
    end

    // Returned pin data to the peripherals
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ext_in_ff <= 3'h0;
            pp_in_ff <= 3'h0;
            ccp_cap_ff <= 1'b0;
            usb_dm_ff <= 1'b0;
            usb_dp_ff <= 1'b0;
        end else begin
            ext_in_ff <= east_pin_in;
            pp_in_ff <= {f_pin_in[3], f_pin_in[4], f_pin_in[5]};
            // capture only while direction is input
            ccp_cap_ff <= e_dir_ff[7] && east_pin_in[2];
            usb_dm_ff <= !usb_off && f_pin_in[1];
            usb_dp_ff <= !usb_off && f_pin_in[2];
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign east_pin_out = east_out_ff;
    assign east_pin_oe = east_oe_ff;
    assign f_pin_out = f_out_ff;
    assign f_pin_oe = f_oe_ff;
    assign extmem_ad_in = ext_in_ff;
    assign parport_data_in = pp_in_ff;
    assign capcomp2_capture = ccp_cap_ff;
    assign usb_dm_in = usb_dm_ff;
    assign usb_dp_in = usb_dp_ff;
    assign port_d_pullup_en = pg_ff[pef_pkg::PEF_PG_DPU_BIT];
    assign port_e_pullup_en = pg_ff[pef_pkg::PEF_PG_EPU_BIT];
    assign port_j_pullup_en = pg_ff[pef_pkg::PEF_PG_JPU_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_plain_pin;
        !f_dir_ff[2] |=> f_pin_oe[0] && f_pin_out[0] == $past(f_lat_ff[2]);
    endproperty
    a_plain_pin: assert property (p_plain_pin) else $error("RF2 not driving latch");
    property p_ext_wins;
        ext_active |=> east_pin_oe == {3{$past(extmem_oe)}};
    endproperty
    a_ext_wins: assert property (p_ext_wins) else $error("memory bus lost pin control");
    property p_ext_data;
        ext_active && extmem_oe |=> east_pin_out == $past(extmem_ad_out);
    endproperty
    a_ext_data: assert property (p_ext_data) else $error("memory data not on pins");
    property p_no_ext_small;
        !PIN80 && extmem_en && extmem_oe && e_dir_ff[5] && !parport_en |=> !east_pin_oe[0];
    endproperty
    a_no_ext_small: assert property (p_no_ext_small) else $error("memory bus on small package");
    property p_pp_addr;
        !ext_active && parport_en && cfg_ff[pef_pkg::PEF_CFG_PPMX_BIT] && !pwm1_active && !pwm2_active
            && !capcomp2_en |=> east_pin_oe == 3'h7
            && east_pin_out == {$past(parport_address_9), $past(parport_address_10), $past(parport_address_11)};
    endproperty
    a_pp_addr: assert property (p_pp_addr) else $error("parallel address wrong");
    property p_pwm_hiz;
        !ext_active && req[1].pwm_en && !e_dir_ff[6] && req[1].pwm_hiz |=> !east_pin_oe[1];
    endproperty
    a_pwm_hiz: assert property (p_pwm_hiz) else $error("PWM pin driven in shutdown");
    property p_j_pullup;
        !PIN80 |-> !port_j_pullup_en;
    endproperty
    a_j_pullup: assert property (p_j_pullup) else $error("J pull-up on small package");
    property p_analog_read;
        psel && !penable && !pwrite && paddr == pef_pkg::PEF_OFF_PF_PIN
            && !ana_lo_ff[pef_pkg::PEF_ANA_RF2_BIT] |=> prdata[2] == 1'b0;
    endproperty
    a_analog_read: assert property (p_analog_read) else $error("analog pin read nonzero");
    property p_usb_dir;
        !usb_off |=> f_pin_oe[2:1] == {2{$past(usb_oe)}};
    endproperty
    a_usb_dir: assert property (p_usb_dir) else $error("USB direction not followed");
    property p_usb_off_in;
        usb_off |=> f_pin_oe[2:1] == 2'h0;
    endproperty
    a_usb_off_in: assert property (p_usb_off_in) else $error("RF3/RF4 driven as GPIO");
    property p_apb_wait;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("APB ready timing wrong");
    c_ext: cover property (ext_active && extmem_oe);
    c_pwm: cover property (req[0].pwm_en && !e_dir_ff[5]);
    c_usb: cover property (!usb_off && usb_oe);
    c_wr: cover property (wr_en && paddr == pef_pkg::PEF_OFF_PE_PIN);
endmodule

// *** pef_board.sv ***
// Purpose: Board-side model of the pins shared by port E and port F.
// Assumes: The board drives a pin only while the device leaves it released.
// Notes: Board levels come from the bench, so every released pin is known.
module pef_board (
    input wire logic [2:0] e_out,
    input wire logic [2:0] e_oe,
    input wire logic [5:0] f_out,
    input wire logic [5:0] f_oe,
    input wire logic [2:0] e_drv,
    input wire logic [5:0] f_drv,
    output logic [2:0] e_in,
    output logic [5:0] f_in
);
    timeunit 1ns;
    timeprecision 1ns;
    assign e_in = (e_oe & e_out) | (~e_oe & e_drv);
    assign f_in = (f_oe & f_out) | (~f_oe & f_drv);
endmodule

// *** port_e_f_pin_mux_test.sv ***
// Purpose: Self-checking bench for the port E/F pin multiplexer.
// Assumes: APB slave answers after one wait state; 80-pin variant.
// Notes: A reference model of registers and pin priority is kept in the bench.
module port_e_f_pin_mux_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] e_in, e_out, e_oe, e_drv = 3'h0, ext_d = 3'h0, ext_in, pd_out = 3'h0, pd_in;
    logic [5:0] f_in, f_out, f_oe, f_drv = 6'h00;
    logic ext_en = 0, ext_oe = 0, pp_en = 0, a9 = 0, a10 = 0, a11 = 0, pd_en = 0, pd_oe = 0;
    logic pw1 = 0, pw2 = 0, p1b = 0, p1c = 0, p2a = 0, shut = 0, cc_en = 0, cc_d = 0, cc_cap;
    logic usb_oe = 0, usb_dm = 0, usb_dp = 0, dm_in, dp_in, pu_d, pu_e, pu_j;
    logic [2:0] xoe, xout;
    int failures = 0, compares = 0, seed = 72142, cycles = 0;
    int mreg[11] = '{0, 0, 8'hFF, 0, 0, 0, 8'hFC, 0, 0, 0, 8'h07};
    int msk[11] = '{8'hFF, 8'hFF, 8'hFF, 8'hE0, 8'hFC, 8'hFC, 8'hFC, 8'hFF, 8'hFF, 8'hFF, 8'h0F};
    int rw[6] = '{1, 2, 3, 5, 6, 10};
    pef_port_ef uut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .east_pin_in(e_in), .east_pin_out(e_out), .east_pin_oe(e_oe),
        .f_pin_in(f_in), .f_pin_out(f_out), .f_pin_oe(f_oe), .extmem_en(ext_en),
        .extmem_oe(ext_oe), .extmem_ad_out(ext_d), .extmem_ad_in(ext_in), .parport_en(pp_en),
        .parport_address_9(a9), .parport_address_10(a10), .parport_address_11(a11),
        .parport_data_en(pd_en), .parport_data_oe(pd_oe), .parport_data_out(pd_out),
        .parport_data_in(pd_in), .pwm1_active(pw1), .pwm2_active(pw2), .pwm1_channel_b(p1b),
        .pwm1_channel_c(p1c), .pwm2_channel_a(p2a), .pwm_shutdown(shut), .capcomp2_en(cc_en),
        .capcomp2_out(cc_d), .capcomp2_capture(cc_cap), .usb_oe(usb_oe), .usb_dm_out(usb_dm),
        .usb_dp_out(usb_dp), .usb_dm_in(dm_in), .usb_dp_in(dp_in), .port_d_pullup_en(pu_d),
        .port_e_pullup_en(pu_e), .port_j_pullup_en(pu_j));
    pef_board board (.e_out(e_out), .e_oe(e_oe), .f_out(f_out), .f_oe(f_oe), .e_drv(e_drv),
        .f_drv(f_drv), .e_in(e_in), .f_in(f_in));
    initial forever #25 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            failures++;
            complete_run;
        end
    end
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("FAIL %0t register got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_pin(input logic [5:0] g, input logic [5:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("FAIL %0t pin got %b exp %b", $time, g, e);
        end
    endtask
    // Idle edge first, so a release and the next setup never share a step
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        int i;
        @(posedge core_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40)
            failures++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        i = (a == 8'h00) ? 1 : (a == 8'h10) ? 5 : a / 4;
        if (w && a < 8'h2C)
            mreg[i] = d & msk[i];
    endtask
    function automatic logic [1:0] exp_e(input int i);
        logic dir;
        logic pe;
        dir = mreg[2][5 + i];
        pe = (i < 2) ? (mreg[10][0] & pw1) : (!mreg[10][1] & pw2);
        if (ext_en)
            return {ext_oe, ext_d[i]};
        if (pe && !dir)
            return {!(shut && mreg[10][3]), (i == 0) ? p1c : (i == 1) ? p1b : p2a};
        if (i == 2 && cc_en && !mreg[10][1] && !dir)
            return {1'b1, cc_d};
        if (pp_en && mreg[10][2])
            return {1'b1, (i == 0) ? a11 : (i == 1) ? a10 : a9};
        return {!dir, mreg[1][5 + i]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge core_clk);
        resetn <= 1;
        foreach (rw[k]) begin
            apb(0, 8'(rw[k] * 4), 8'h00);
            chk_reg(rd, mreg[rw[k]]);
        end
        repeat (3) foreach (rw[k]) begin
            apb(1, 8'(rw[k] * 4), 8'($random(seed)));
            apb(0, 8'(rw[k] * 4), 8'h00);
            chk_reg(rd, mreg[rw[k]]);
        end
        chk_pin({3'h0, pu_d, pu_e, pu_j}, {3'h0, mreg[3][7:5]});
        apb(1, 8'h00, 8'hA5);
        apb(0, 8'h04, 8'h00);
        chk_reg(rd, 32'hA5);
        apb(1, 8'h10, 8'h5A);
        apb(0, 8'h14, 8'h00);
        chk_reg(rd, 32'h58);
        apb(1, 8'h2C, 8'hFF);
        chk_pin({5'h0, err}, 6'h01);
        f_drv <= 6'h3F;
        apb(1, 8'h28, 8'h07);
        apb(1, 8'h18, 8'hFC);
        apb(0, 8'h10, 8'h00);
        chk_reg(rd, 32'h80);
        apb(1, 8'h1C, 8'h80);
        apb(1, 8'h20, 8'h0C);
        apb(1, 8'h24, 8'h08);
        apb(0, 8'h10, 8'h00);
        chk_reg(rd, 32'hFC);
        apb(1, 8'h18, 8'h00);
        repeat (2) @(posedge core_clk);
        chk_pin(f_oe, 6'b111001);
        chk_pin(f_out & 6'b111001, mreg[5][7:2] & 6'b111001);
        chk_pin({4'h0, dm_in, dp_in}, 6'h00);
        usb_oe <= 1;
        usb_dp <= 1;
        apb(1, 8'h24, 8'h00);
        repeat (2) @(posedge core_clk);
        chk_pin({2'h0, f_oe[2:1], f_out[2:1]}, 6'b001110);
        repeat (40) begin
            {ext_en, ext_oe, ext_d, pp_en, a9, a10, a11, pw1, pw2, p1b, p1c, p2a} <= 14'($random(seed));
            {shut, cc_en, cc_d, e_drv, pd_en, pd_oe, pd_out, usb_oe, usb_dm, usb_dp} <= 14'($random(seed));
            apb(1, 8'h08, 8'($random(seed)));
            apb(1, 8'h28, 8'($random(seed)));
            apb(1, 8'h04, 8'($random(seed)));
            ext_en <= ($random(seed) % 4 == 0);
            repeat (3) @(posedge core_clk);
            for (int i = 0; i < 3; i++)
                {xoe[i], xout[i]} = exp_e(i);
            chk_pin({3'h0, e_oe}, {3'h0, xoe});
            chk_pin({3'h0, e_out & xoe}, {3'h0, xout & xoe});
            apb(0, 8'h00, 8'h00);
            chk_reg(rd, {24'h0, (xoe & xout) | (~xoe & e_drv), 5'h0});
            chk_pin({5'h0, cc_cap}, {5'h0, e_in[2] & mreg[2][7]});
            chk_pin({3'h0, ext_in}, {3'h0, e_in});
            // Port F bits 7:5 are outputs here, latch holds 0x58
            for (int i = 0; i < 3; i++)
                {xoe[i], xout[i]} = (pd_en && !mreg[10][2]) ? {pd_oe, pd_out[2 - i]} : {1'b1, mreg[5][5 + i]};
            chk_pin({3'h0, f_oe[5:3]}, {3'h0, xoe});
            chk_pin({3'h0, f_out[5:3] & xoe}, {3'h0, xout & xoe});
            chk_pin({1'b0, pd_in, dm_in, dp_in}, {1'b0, f_in[3], f_in[4], f_in[5], f_in[1], f_in[2]});
        end
        complete_run;
    end
endmodule
